/* rtl/gpx_cfg.svh */
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH

// Fixed upper six bits of the target address, most significant first.
`define GPX_ADDR_HI      6'h10
// Register selectors carried in the low bits of the command byte.
`define GPX_REG_INPUT    2'h0
`define GPX_REG_OUTPUT   2'h1
`define GPX_REG_POLARITY 2'h2
`define GPX_REG_CONFIG   2'h3
// Reset values.
`define GPX_OUT_RST      8'hFF
`define GPX_POL_RST      8'h00
`define GPX_CFG_RST      8'hFF
`define GPX_CMD_RST      8'h00
// Bits in one byte of a transfer.
`define GPX_BYTE_BITS    4'h8

`endif

/* rtl/gpx_pkg.sv */
package gpx_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_IGNORE
  } bus_state_e;

  typedef logic [7:0] port_byte_t;

endpackage

/* rtl/bus_edge_sync.sv */
`timescale 1ns/1ps

module bus_edge_sync
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_i,
  // Raw two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Synchronised levels and events
  output logic      scl_o,
  output logic      sda_o,
  output logic      scl_rise_o,
  output logic      scl_fall_o,
  output logic      start_o,
  output logic      stop_o
);

  logic [1:0] scl_meta_q;
  logic [1:0] sda_meta_q;

  // Only the second stage feeds logic; the first absorbs metastability.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_o      <= 1'b1;
      sda_o      <= 1'b1;
    end
    else
    begin
      scl_meta_q <= {scl_meta_q[0], scl_i};
      sda_meta_q <= {sda_meta_q[0], sda_i};
      scl_o      <= scl_meta_q[1];
      sda_o      <= sda_meta_q[1];
    end
  end

  assign scl_rise_o = scl_meta_q[1] & ~scl_o;
  assign scl_fall_o = ~scl_meta_q[1] & scl_o;
  assign start_o    = scl_meta_q[1] & scl_o & sda_o & ~sda_meta_q[1];
  assign stop_o     = scl_meta_q[1] & scl_o & ~sda_o & sda_meta_q[1];

endmodule

/* rtl/i2c_gpio_expander_8bit.sv */
`timescale 1ns/1ps
`include "gpx_cfg.svh"

module i2c_gpio_expander_8bit
  import gpx_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // External reset pin and supply monitor
  input  wire logic       reset_n_i,
  input  wire logic       port_supply_ok_i,
  // Two-wire bus
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_sel_i,
  // Port pins
  input  wire logic [7:0] expander_pins_i,
  output logic      [7:0] expander_pins_o,
  output logic      [7:0] expander_pins_oe_o,
  // Change alert, open drain
  output logic            alert_n_o,
  output logic            alert_n_oe_o
);

  // ------------------------------------------------------------
  // Reset pin, supply and address strap synchronisers
  // ------------------------------------------------------------
  logic [1:0]   rst_meta_q;
  logic [1:0]   sup_meta_q;
  logic [1:0]   adr_meta_q;
  logic         rst;

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      rst_meta_q <= 2'h0;
      sup_meta_q <= 2'h0;
      adr_meta_q <= 2'h0;
    end
    else
    begin
      rst_meta_q <= {rst_meta_q[0], reset_n_i};
      sup_meta_q <= {sup_meta_q[0], port_supply_ok_i};
      adr_meta_q <= {adr_meta_q[0], addr_sel_i};
    end
  end

  // The supply monitor provides the re-arm hysteresis; here a low level
  // simply holds the block in reset until it is good again.
  assign rst = sys_rst_i | ~rst_meta_q[1] | ~sup_meta_q[1];

  // ------------------------------------------------------------
  // Bus line conditioning
  // ------------------------------------------------------------
  logic         scl_s;
  logic         sda_s;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;

  bus_edge_sync bus_edge_sync_inst
  (
    .mclk_i     (mclk_i),
    .rst_i      (rst),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_o      (scl_s),
    .sda_o      (sda_s),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_det),
    .stop_o     (stop_det)
  );

  // ------------------------------------------------------------
  // Port pin synchroniser
  // ------------------------------------------------------------
  port_byte_t   pin_meta_q;
  port_byte_t   pin_s_q;

  always_ff @(posedge mclk_i)
  begin
    pin_meta_q <= expander_pins_i;
    pin_s_q    <= pin_meta_q;
  end

  // ------------------------------------------------------------
  // Registers and bus state
  // ------------------------------------------------------------
  bus_state_e   state_q;
  logic [3:0]   cnt_q;
  port_byte_t   sh_q;
  port_byte_t   tx_q;
  port_byte_t   cmd_q;
  port_byte_t   in_q;
  port_byte_t   out_q;
  port_byte_t   pol_q;
  port_byte_t   cfg_q;
  logic         rw_q;
  logic         mack_q;
  logic         load_q;
  logic         sda_oe_q;
  logic         alert_q;

  wire          byte_done   = scl_fall & (cnt_q == `GPX_BYTE_BITS);
  wire  [6:0]   my_addr     = {`GPX_ADDR_HI, adr_meta_q[1]};
  wire          addr_match  = (sh_q[7:1] == my_addr);
  wire  [1:0]   reg_sel     = cmd_q[1:0];
  wire          sel_input   = (reg_sel == `GPX_REG_INPUT);
  wire          sel_output  = (reg_sel == `GPX_REG_OUTPUT);
  wire          sel_pol     = (reg_sel == `GPX_REG_POLARITY);
  wire          wr_fire     = (state_q == ST_WDATA) & byte_done;
  wire          wr_out_fire = wr_fire & sel_output;
  wire          rd_clear    = (state_q == ST_RDATA_ACK) & scl_rise & sel_input;
  wire          shifting    = scl_rise & (cnt_q != `GPX_BYTE_BITS);

  // Input value as presented on a read, bit n from pin n.
  wire  port_byte_t rd_input = pin_s_q ^ pol_q;

  port_byte_t   rd_byte;
  assign rd_byte = sel_input  ? rd_input :
                   sel_output ? out_q    :
                   sel_pol    ? pol_q    : cfg_q;

  // Only pins configured as inputs take part in the comparison.
  wire  port_byte_t mism = (pin_s_q ^ in_q) & cfg_q;

  // ------------------------------------------------------------
  // Two-wire target state machine
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst)
    begin
      state_q  <= ST_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'b0;
      mack_q   <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q  <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (start_det)
    begin
      // A start is honoured in any state, so requests are always taken.
      state_q  <= ST_ADDR;
      cnt_q    <= 4'h0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      if (shifting)
      begin
        sh_q  <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end
      case (state_q)
        ST_ADDR:
        begin
          if (byte_done)
          begin
            cnt_q <= 4'h0;
            if (addr_match)
            begin
              state_q  <= ST_ADDR_ACK;
              rw_q     <= sh_q[0];
              sda_oe_q <= 1'b1;
            end
            else
            begin
              state_q <= ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            // The acknowledge rise has bumped the count, so restart it here.
            cnt_q <= 4'h0;
            if (rw_q)
            begin
              state_q  <= ST_RDATA;
              sda_oe_q <= ~rd_byte[7];
              tx_q     <= {rd_byte[6:0], 1'b0};
            end
            else
            begin
              state_q  <= ST_CMD;
              sda_oe_q <= 1'b0;
            end
          end
        end
        ST_CMD:
        begin
          if (byte_done)
          begin
            state_q  <= ST_CMD_ACK;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b1;
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            cnt_q    <= 4'h0;
            state_q  <= ST_WDATA;
            sda_oe_q <= 1'b0;
          end
        end
        ST_WDATA:
        begin
          if (byte_done)
          begin
            state_q  <= ST_WDATA_ACK;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b1;
          end
        end
        ST_RDATA:
        begin
          if (byte_done)
          begin
            state_q  <= ST_RDATA_ACK;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
          end
          else if (scl_fall)
          begin
            sda_oe_q <= ~tx_q[7];
            tx_q     <= {tx_q[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK:
        begin
          if (scl_rise)
          begin
            mack_q <= ~sda_s;
          end
          if (scl_fall)
          begin
            cnt_q <= 4'h0;
            if (mack_q)
            begin
              state_q  <= ST_RDATA;
              sda_oe_q <= ~rd_byte[7];
              tx_q     <= {rd_byte[6:0], 1'b0};
            end
            else
            begin
              state_q <= ST_IGNORE;
            end
          end
        end
        default:
        begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Command and port registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (rst)
    begin
      cmd_q <= `GPX_CMD_RST;
      out_q <= `GPX_OUT_RST;
      pol_q <= `GPX_POL_RST;
      cfg_q <= `GPX_CFG_RST;
    end
    else if ((state_q == ST_CMD) && byte_done)
    begin
      cmd_q <= sh_q;
    end
    else if (wr_fire)
    begin
      // Writes to the input register are dropped on purpose.
      if (sel_output)
        out_q <= sh_q;
      else if (sel_pol)
        pol_q <= sh_q;
      else if (reg_sel == `GPX_REG_CONFIG)
        cfg_q <= sh_q;
    end
  end

  // ------------------------------------------------------------
  // Input register and change alert
  // ------------------------------------------------------------
  // The capture after reset waits one cycle so it sees live pin levels.
  // A pin edge landing in the same cycle as the read capture is absorbed
  // into the new reference and never alerts; that is the accepted loss.
  always_ff @(posedge mclk_i)
  begin
    if (rst)
    begin
      load_q  <= 1'b1;
      in_q    <= 8'h00;
      alert_q <= 1'b0;
    end
    else
    begin
      load_q <= 1'b0;
      if (load_q || rd_clear)
        in_q <= pin_s_q;
      alert_q <= ~load_q & ~rd_clear & (|mism);
    end
  end

  assign sda_o              = 1'b0;
  assign sda_oe_o           = sda_oe_q;
  assign expander_pins_o    = out_q;
  assign expander_pins_oe_o = ~cfg_q;
  assign alert_n_o          = 1'b0;
  assign alert_n_oe_o       = alert_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst);

  sequence addr_hit_s;
    (state_q == ST_ADDR) && byte_done && addr_match;
  endsequence

  sequence ack_slot_s;
    sda_oe_o && (state_q == ST_ADDR_ACK);
  endsequence

  a_input_no_drive: assert property (
    $rose(cfg_q[0]) |-> !expander_pins_oe_o[0])
    else $error("input pin still driven");

  a_output_write: assert property (
    wr_out_fire |=> (expander_pins_o == $past(sh_q)))
    else $error("output byte not driven");

  a_alert_raise: assert property (
    (!load_q && !rd_clear && (|mism)) |=> !alert_n_o && alert_n_oe_o)
    else $error("input change not alerted");

  a_alert_return: assert property (
    (mism == 8'h00) |=> !alert_n_oe_o)
    else $error("alert stuck after pin returned");

  a_read_clears: assert property (
    rd_clear |=> (in_q == $past(pin_s_q)) ##0 !alert_n_oe_o)
    else $error("port read did not clear alert");

  a_outputs_quiet: assert property (
    (cfg_q == 8'h00) |=> !alert_n_oe_o)
    else $error("output pin caused alert");

  a_foreign_ignored: assert property (
    (state_q == ST_IGNORE)[*2] |-> !sda_oe_o && $stable(in_q))
    else $error("foreign transfer disturbed device");

  a_reset_inputs: assert property (
    $past(rst) |-> (cfg_q == `GPX_CFG_RST) && (expander_pins_oe_o == 8'h00))
    else $error("pins not inputs after reset");

  a_address_ack: assert property (
    addr_hit_s |=> ack_slot_s)
    else $error("own address not acknowledged");

endmodule

/* verif/i2c_ctrl_model.sv */
`timescale 1ns/1ps

module i2c_ctrl_model
(
  // Two-wire bus
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  // ----------------------------------------
  // Bus controller
  // ----------------------------------------
  // A quarter of the 125 ns bus period. The clock stands high between frames.
  localparam realtime Q = 31.25;

  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // The bus is idle here after a stop, except for the repeated start in read_reg.
  task automatic start_cond();
    sda_low_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  task automatic stop_cond();
    sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #(4*Q);
  endtask

  task automatic bit_xfer(input logic b, output logic r);
    sda_low_o = ~b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] cmd,
                           input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start_cond();
    send_byte({a, 1'b0}, k1);
    send_byte(cmd, k2);
    send_byte(d, k3);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask

  task automatic read_reg(input logic [6:0] a, input logic [7:0] cmd,
                          output logic [7:0] d, output logic ok);
    logic k1, k2, k3, r;
    start_cond();
    send_byte({a, 1'b0}, k1);
    send_byte(cmd, k2);
    start_cond();
    send_byte({a, 1'b1}, k3);
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(1'b1, r);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask
endmodule

/* verif/i2c_gpio_expander_8bit_bench.sv */
`timescale 1ns/1ps

module i2c_gpio_expander_8bit_bench;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic       mclk_i           = 1'b0;
  logic       sys_rst_i        = 1'b1;
  logic       reset_n_i        = 1'b1;
  logic       port_supply_ok_i = 1'b1;
  logic       addr_sel_i       = 1'b0;
  logic [7:0] pins_ext         = 8'h5A;
  logic       scl;
  logic       sda_low;
  logic       sda_o;
  logic       sda_oe_o;
  logic       alert_n_o;
  logic       alert_n_oe_o;
  logic [7:0] pins_o;
  logic [7:0] pins_oe;
  logic [7:0] rd;
  logic       ok;
  int         n_mismatch       = 0;
  int         check_count      = 0;
  // The data line has a pull-up, so a released line reads high.
  wire        sda_w            = ~(sda_low | sda_oe_o);
  wire  [7:0] pin_lvl          = (pins_oe & pins_o) | (~pins_oe & pins_ext);

  always #4 mclk_i = ~mclk_i;

  i2c_gpio_expander_8bit i2c_gpio_expander_8bit_inst (
    .mclk_i             (mclk_i),
    .sys_rst_i          (sys_rst_i),
    .reset_n_i          (reset_n_i),
    .port_supply_ok_i   (port_supply_ok_i),
    .scl_i              (scl),
    .sda_i              (sda_w),
    .sda_o              (sda_o),
    .sda_oe_o           (sda_oe_o),
    .addr_sel_i         (addr_sel_i),
    .expander_pins_i    (pin_lvl),
    .expander_pins_o    (pins_o),
    .expander_pins_oe_o (pins_oe),
    .alert_n_o          (alert_n_o),
    .alert_n_oe_o       (alert_n_oe_o)
  );

  i2c_ctrl_model i2c_ctrl_model_inst (
    .scl_o     (scl),
    .sda_low_o (sda_low),
    .sda_i     (sda_w)
  );

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic set_pins(input logic [7:0] v);
    @(posedge mclk_i);
    #1 pins_ext = v;
    wait_cyc(8);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string w);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  task automatic chk_alert(input logic e, input string w);
    check({7'h00, alert_n_oe_o}, {7'h00, e}, w);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    #300us;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    wait_cyc(8);
    check(pins_oe, 8'h00, "direction after reset");
    check(pins_o, 8'hFF, "output after reset");
    check({6'h00, alert_n_o, sda_o}, 8'h00, "open drain values");
    chk_alert(1'b0, "alert after reset");
    $display("test reset done");
    i2c_ctrl_model_inst.write_reg(7'h20, 8'h01, 8'hA5, ok);
    check({7'h00, ok}, 8'h01, "write acknowledge");
    i2c_ctrl_model_inst.write_reg(7'h20, 8'h03, 8'h0F, ok);
    wait_cyc(8);
    check(pins_oe, 8'hF0, "direction");
    check(pins_o, 8'hA5, "driven levels");
    chk_alert(1'b0, "output activity");
    i2c_ctrl_model_inst.read_reg(7'h20, 8'h03, rd, ok);
    check(rd, 8'h0F, "direction readback");
    $display("test direction done");
    set_pins(8'h5B);
    chk_alert(1'b1, "rising input");
    set_pins(8'h5A);
    chk_alert(1'b0, "input restored");
    set_pins(8'h58);
    chk_alert(1'b1, "falling input");
    i2c_ctrl_model_inst.write_reg(7'h21, 8'h01, 8'h00, ok);
    check({7'h00, ok}, 8'h00, "other target refused");
    check(pins_o, 8'hA5, "other target no write");
    chk_alert(1'b1, "other target keeps alert");
    i2c_ctrl_model_inst.read_reg(7'h20, 8'h00, rd, ok);
    check(rd, 8'hA8, "input port read");
    wait_cyc(8);
    chk_alert(1'b0, "read clears alert");
    set_pins(8'h59);
    chk_alert(1'b1, "alert after clear");
    i2c_ctrl_model_inst.write_reg(7'h20, 8'h02, 8'h03, ok);
    i2c_ctrl_model_inst.read_reg(7'h20, 8'h00, rd, ok);
    check(rd, 8'hAA, "inverted input read");
    $display("test alert done");
    reset_n_i = 1'b0;
    wait_cyc(6);
    check(pins_oe, 8'h00, "reset pin direction");
    check(pins_o, 8'hFF, "reset pin output");
    chk_alert(1'b0, "reset pin alert");
    reset_n_i = 1'b1;
    wait_cyc(8);
    chk_alert(1'b0, "alert after reset pin");
    i2c_ctrl_model_inst.read_reg(7'h20, 8'h02, rd, ok);
    check(rd, 8'h00, "polarity after reset pin");
    i2c_ctrl_model_inst.write_reg(7'h20, 8'h03, 8'h00, ok);
    check({7'h00, ok}, 8'h01, "accepted after reset");
    wait_cyc(8);
    check(pins_oe, 8'hFF, "all outputs");
    port_supply_ok_i = 1'b0;
    wait_cyc(6);
    check(pins_oe, 8'h00, "supply low direction");
    port_supply_ok_i = 1'b1;
    wait_cyc(8);
    i2c_ctrl_model_inst.read_reg(7'h20, 8'h03, rd, ok);
    check(rd, 8'hFF, "direction after power reset");
    $display("test reset pin and supply done");
    give_verdict();
  end
endmodule
